/* shared/pass_thru_regs.svh */
// Register offsets, reset values and synchroniser width of the local register bank.
`ifndef PASS_THRU_REGS_SVH
`define PASS_THRU_REGS_SVH

// ------
// Local register byte offsets (7-bit byte address).
// ------
`define OFS_INCOMING_MBOX 7'h0C
`define OFS_OUTGOING_MBOX 7'h1C
`define OFS_TRANSFER_ADDR 7'h28
`define OFS_TRANSFER_DATA 7'h2C
`define OFS_MBOX_STATUS 7'h34
`define OFS_LOCAL_INT_CTRL 7'h38
`define OFS_LOCAL_RST_CTRL 7'h3C
`define OFS_REGION_CONFIG 7'h60

// ------
// Reset values and constant answers.
// ------
`define REGION_CONFIG_RESET 32'h80808080
`define ZERO_WORD 32'h00000000
`define ADDR_LOW_BITS 2'h0

// ------
// Pin synchroniser vector layout.
// ------
`define SYNC_WIDTH 47

`endif

/* shared/pass_thru_pkg.sv */
// Types shared by the pass-through register bank and its helpers.
package pass_thru_pkg;

  // Pass-through sequencer states.
  typedef enum logic [1:0] {PT_IDLE, PT_STROBE, PT_WAIT, PT_PASSIVE} pt_state_type;

  // Layout of one region byte of the configuration word, msb first.
  typedef struct packed {
    logic strobe_mode;
    logic big_endian;
    logic wfifo_bypass;
    logic [1:0] prefetch;
    logic [2:0] wait_states;
  } region_cfg_type;

endpackage : pass_thru_pkg

/* shared/cfg_port_if.sv */
// Write ports of both buses into the shared configuration word, and its value.
`timescale 1ns/10ps

interface cfg_port_if;
  logic host_we; // Host side write strobe.
  logic [3:0] host_be; // Host side byte enables.
  logic [31:0] host_data; // Host side write data.
  logic loc_we; // Local side write strobe.
  logic [3:0] loc_be; // Local side byte enables.
  logic [31:0] loc_data; // Local side write data.
  logic [31:0] value; // Current configuration word.
  modport store (input host_we, host_be, host_data, loc_we, loc_be, loc_data, output value);
  modport user (output host_we, host_be, host_data, loc_we, loc_be, loc_data, input value);
endinterface : cfg_port_if

/* hdl/pin_sync.sv */
// Two flip-flop synchroniser for a bundle of pins from outside the clock domain.
`timescale 1ns/10ps

module pin_sync #(
  parameter int unsigned WIDTH = 1 // Number of pins carried.
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg; // First stage, read only by the second stage.

  // ------
  // Both stages.
  // ------
  // The first stage may go metastable, so nothing but the second stage reads it.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      meta_reg <= '0;
      o_sync <= '0;
    end
    else if (i_ce)
    begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end

endmodule : pin_sync

/* hdl/region_cfg_store.sv */
// Single physical configuration word written from the host bus and the local bus.
`timescale 1ns/10ps
`include "pass_thru_regs.svh"

module region_cfg_store (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  cfg_port_if.store port
);

  logic [31:0] cfg_reg; // The one stored word.

  assign port.value = cfg_reg;

  // ------
  // One byte lane per region.
  // ------
  // Writes in separate cycles simply leave the later one behind. When both sides
  // hit the same lane in one cycle the host write is taken.
  for (genvar lane = 0; lane < 4; lane++)
  begin : g_lane
    always_ff @(posedge i_clk)
    begin
      if (!i_rst_n)
        cfg_reg[lane*8 +: 8] <= 8'(`REGION_CONFIG_RESET >> (lane*8)); // R1
      else if (i_ce)
      begin
        if (port.host_we && port.host_be[lane])
          cfg_reg[lane*8 +: 8] <= port.host_data[lane*8 +: 8]; // R3
        else if (port.loc_we && port.loc_be[lane])
          cfg_reg[lane*8 +: 8] <= port.loc_data[lane*8 +: 8]; // R23
      end
    end
  end

endmodule : region_cfg_store

/* hdl/pass_thru_local_regs.sv */
// Local register bank and pass-through sequencer of the bridge's add-on side.
//
// How it works
// R1: one 32-bit config word, resets 80808080h.
// R2: byte n configures pass-through region n+1.
// R3: host and local share one word, last write wins.
// R4: others must not retune during a transfer.
// R5: active strobe mode pulses strobe one clock, drives address.
// R6: strobe mode bit ignored in passive mode.
// R7: bit 6 swaps local data to big endian.
// R8: bit 5 accepts next write after previous taken.
// R9: bit 5 clear buffers writes until FIFO full.
// R10: bits 4:3 pick prefetch after each read.
// R11: prefetch works in active and passive mode.
// R12: active mode waits programmed clocks per data phase.
// R13: wait input held low stretches the data phase.
// R14: wait count ignored in passive mode.
// R15: select, byte enables, read or write strobe.
// R16: local pins sampled on add-on clock edges.
// R17: other must avoid unmapped local addresses.
// R18: decode the eight documented local offsets; only five are decoded, status, interrupt and reset control read as zero.
// R19: incoming mailbox is read only locally.
// R20: incoming mailbox read may raise host interrupt.
// R21: incoming mailbox is host outgoing mailbox storage.
// R22: passive transfers wait for local data register access.
// R23: config writes touch only enabled byte lanes.
`timescale 1ns/10ps
`include "pass_thru_regs.svh"

module pass_thru_local_regs
  import pass_thru_pkg::*;
#(
  parameter int unsigned WFIFO_DEPTH = 8 // Write FIFO depth in DWORDs, a power of two.
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_addon_clk,
  input wire logic i_select_n,
  input wire logic [3:0] i_byte_enables,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [6:2] i_addr,
  input wire logic [31:0] i_data,
  output logic [31:0] o_data,
  output logic o_data_oe,
  input wire logic i_active_mode,
  input wire logic i_transfer_wait_n,
  output logic o_transfer_attention_n,
  output logic o_transfer_addr_strobe_n,
  input wire logic i_host_cfg_we,
  input wire logic [3:0] i_host_cfg_be,
  input wire logic [31:0] i_host_cfg_wdata,
  output logic [31:0] o_host_cfg_rdata,
  input wire logic i_host_mbox_we,
  input wire logic [3:0] i_host_mbox_be,
  input wire logic [31:0] i_host_mbox_wdata,
  output logic [31:0] o_host_mbox_rdata,
  input wire logic i_host_irq_en,
  output logic o_host_irq,
  input wire logic i_pt_valid,
  output logic o_pt_ready,
  input wire logic i_pt_write,
  input wire logic [1:0] i_pt_region,
  input wire logic [31:0] i_pt_addr,
  input wire logic [31:0] i_pt_wdata,
  output logic [31:0] o_pt_rdata,
  output logic o_pt_rvalid,
  output logic o_prefetch_start,
  output logic [1:0] o_prefetch_sel
);

  localparam int unsigned PW = $clog2(WFIFO_DEPTH); // FIFO pointer width.
  localparam int unsigned CW = $clog2(WFIFO_DEPTH + 1); // FIFO count width.

  // ------
  // Pin sampling.
  // ------
  logic [`SYNC_WIDTH-1:0] sync_vec; // Synchronised pins.
  logic clk_s, sel_n_s, rd_n_s, wr_n_s, wait_n_s, active_s; // Synchronised levels.
  logic [3:0] be_s; // Synchronised byte enables.
  logic [6:2] addr_s; // Synchronised word address.
  logic [31:0] data_s; // Synchronised data bus.
  logic clk_q_reg; // Previous add-on clock sample.
  logic rise; // One cycle at each add-on clock rising edge.

  pin_sync #(.WIDTH(`SYNC_WIDTH)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_async({i_addon_clk, i_select_n, i_rd_n, i_wr_n, i_transfer_wait_n, i_active_mode,
              i_byte_enables, i_addr, i_data}),
    .o_sync(sync_vec)
  );

  assign {clk_s, sel_n_s, rd_n_s, wr_n_s, wait_n_s, active_s, be_s, addr_s, data_s} = sync_vec;

  // Edge finder on the second synchroniser stage only.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      clk_q_reg <= 1'b0;
    else if (i_ce)
      clk_q_reg <= clk_s;
  end

  assign rise = clk_s && !clk_q_reg; // R16

  // ------
  // Access decode.
  // ------
  logic [6:0] byte_addr; // Byte address of the local access.
  logic rd_level; // Local read strobe active with select.
  logic acc_rd, acc_wr; // Access taken at an add-on edge.
  logic [31:0] cfg_value; // Shared configuration word.

  assign byte_addr = {addr_s, `ADDR_LOW_BITS};
  assign rd_level = !sel_n_s && !rd_n_s && (be_s != 4'h0);
  assign acc_rd = rise && rd_level; // R15
  assign acc_wr = rise && !sel_n_s && !wr_n_s && (be_s != 4'h0); // R15

  // Merge enabled byte lanes of a write into an old word.
  function automatic logic [31:0] merge_be(input logic [31:0] old_w, input logic [31:0] new_w,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
      if (be[b])
        res[b*8 +: 8] = new_w[b*8 +: 8];
    return res;
  endfunction : merge_be

  // Byte order reversal for big endian regions.
  function automatic logic [31:0] swap_bytes(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction : swap_bytes

  // ------
  // Shared configuration word.
  // ------
  cfg_port_if cfg_if ();

  assign cfg_if.host_we = i_host_cfg_we;
  assign cfg_if.host_be = i_host_cfg_be;
  assign cfg_if.host_data = i_host_cfg_wdata;
  assign cfg_if.loc_we = acc_wr && (byte_addr == `OFS_REGION_CONFIG); // R18
  assign cfg_if.loc_be = be_s;
  assign cfg_if.loc_data = data_s;
  assign cfg_value = cfg_if.value;
  assign o_host_cfg_rdata = cfg_value;

  region_cfg_store u_cfg (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .port(cfg_if.store)
  );

  // ------
  // Mailboxes.
  // ------
  logic [31:0] in_mbox_reg; // Host outgoing mailbox, read locally as incoming.
  logic [31:0] out_mbox_reg; // Local outgoing mailbox, read by the host.
  logic irq_reg; // Host interrupt pulse.

  // Local writes to the incoming mailbox are dropped; only the host fills it.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      in_mbox_reg <= `ZERO_WORD;
    else if (i_ce && i_host_mbox_we)
      in_mbox_reg <= merge_be(in_mbox_reg, i_host_mbox_wdata, i_host_mbox_be); // R21 R19
  end

  // Local outgoing mailbox, any width.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      out_mbox_reg <= `ZERO_WORD;
    else if (i_ce && acc_wr && (byte_addr == `OFS_OUTGOING_MBOX))
      out_mbox_reg <= merge_be(out_mbox_reg, data_s, be_s);
  end

  assign o_host_mbox_rdata = out_mbox_reg;

  // A local read of the incoming mailbox raises a one-cycle host interrupt when enabled.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      irq_reg <= 1'b0;
    else if (i_ce)
      irq_reg <= acc_rd && (byte_addr == `OFS_INCOMING_MBOX) && i_host_irq_en; // R20
  end

  assign o_host_irq = irq_reg;

  // ------
  // Pass-through write FIFO and read request.
  // ------
  logic [65:0] wf_mem [WFIFO_DEPTH]; // Entries of {region, address, data}.
  logic [PW-1:0] wf_wr_ptr, wf_rd_ptr; // FIFO pointers.
  logic [CW-1:0] wf_count; // FIFO fill level.
  logic wf_push, wf_pop, wf_full; // FIFO controls.
  logic rd_job_reg; // A host read waits for the sequencer.
  logic [1:0] rd_region_reg; // Region of the waiting read.
  logic [31:0] rd_addr_reg; // Address of the waiting read.
  pt_state_type state_reg; // Sequencer state.
  logic cur_write_reg; // Current job is a host write.
  logic seq_free; // Sequencer idle and no read waiting.
  region_cfg_type req_cfg; // Configuration of the offered request's region.

  assign wf_full = (wf_count == CW'(WFIFO_DEPTH));
  assign req_cfg = region_cfg_type'(cfg_value[i_pt_region*8 +: 8]); // R2
  assign seq_free = (state_reg == PT_IDLE) && !rd_job_reg;

  // Bypass holds each write until the previous one left the local side.
  always_comb
  begin
    if (!i_pt_write)
      o_pt_ready = seq_free && (wf_count == '0);
    else if (req_cfg.wfifo_bypass)
      o_pt_ready = seq_free && (wf_count == '0); // R8
    else
      o_pt_ready = !wf_full && !rd_job_reg && !((state_reg != PT_IDLE) && !cur_write_reg); // R9
  end

  assign wf_push = i_pt_valid && o_pt_ready && i_pt_write;

  // FIFO storage and pointers.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      wf_wr_ptr <= '0;
      wf_rd_ptr <= '0;
      wf_count <= '0;
    end
    else if (i_ce)
    begin
      if (wf_push)
      begin
        wf_mem[wf_wr_ptr] <= {i_pt_region, i_pt_addr, i_pt_wdata};
        wf_wr_ptr <= wf_wr_ptr + 1'b1;
      end
      if (wf_pop)
        wf_rd_ptr <= wf_rd_ptr + 1'b1;
      if (wf_push && !wf_pop)
        wf_count <= wf_count + 1'b1;
      else if (wf_pop && !wf_push)
        wf_count <= wf_count - 1'b1;
    end
  end

  // Holding register for one host read.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rd_job_reg <= 1'b0;
      rd_region_reg <= 2'h0;
      rd_addr_reg <= `ZERO_WORD;
    end
    else if (i_ce)
    begin
      if (i_pt_valid && o_pt_ready && !i_pt_write)
      begin
        rd_job_reg <= 1'b1;
        rd_region_reg <= i_pt_region;
        rd_addr_reg <= i_pt_addr;
      end
      else if (rise && (state_reg == PT_IDLE) && (wf_count == '0))
        rd_job_reg <= 1'b0;
    end
  end

  // ------
  // Pass-through sequencer, stepped on add-on clock edges.
  // ------
  logic [1:0] cur_region_reg; // Region of the current job.
  logic [31:0] cur_addr_reg, cur_data_reg; // Address and data of the current job.
  logic [2:0] ws_cnt_reg; // Remaining wait states.
  logic attn_n_reg, strobe_n_reg; // Link outputs.
  logic rvalid_reg, pf_start_reg; // Host pulses.
  logic [1:0] pf_sel_reg; // Prefetch size of the last read.
  logic [31:0] rdata_reg; // Read result for the host.
  region_cfg_type cur_cfg, head_cfg; // Configuration of current and next job.
  logic [65:0] wf_head; // FIFO head entry.
  logic start_job; // A job is loaded this edge.
  logic done_job; // The current job finishes this edge.
  logic pt_data_rd, pt_data_wr; // Local access to the transfer data register.
  logic [31:0] pass_in; // Passive read word including this edge's local write.

  assign wf_head = wf_mem[wf_rd_ptr];
  assign cur_cfg = region_cfg_type'(cfg_value[cur_region_reg*8 +: 8]);
  assign head_cfg = region_cfg_type'(cfg_value[(wf_count != '0 ? wf_head[65:64] : rd_region_reg)*8 +: 8]);
  assign start_job = rise && (state_reg == PT_IDLE) && ((wf_count != '0) || rd_job_reg);
  assign wf_pop = start_job && (wf_count != '0);
  assign pt_data_rd = acc_rd && (byte_addr == `OFS_TRANSFER_DATA);
  assign pt_data_wr = acc_wr && (byte_addr == `OFS_TRANSFER_DATA);
  // The write that completes a passive read must reach the answer in the same edge.
  assign pass_in = merge_be(cur_data_reg, cur_cfg.big_endian ? swap_bytes(data_s) : data_s,
                            cur_cfg.big_endian ? {be_s[0], be_s[1], be_s[2], be_s[3]} : be_s); // R7

  // Completion of the data phase in either mode.
  always_comb
  begin
    case (state_reg)
      PT_WAIT: done_job = rise && wait_n_s && (ws_cnt_reg == 3'h0); // R12 R13
      PT_PASSIVE: done_job = cur_write_reg ? pt_data_rd : pt_data_wr; // R22
      default: done_job = 1'b0;
    endcase
  end

  // State, link strobes and wait counting. The strobe drops together with the
  // attention signal and lasts one add-on clock.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_reg <= PT_IDLE;
      attn_n_reg <= 1'b1;
      strobe_n_reg <= 1'b1;
      ws_cnt_reg <= 3'h0;
    end
    else if (i_ce)
    begin
      case (state_reg)
        PT_IDLE:
        begin
          if (start_job)
          begin
            attn_n_reg <= 1'b0;
            ws_cnt_reg <= head_cfg.wait_states;
            if (!active_s)
              state_reg <= PT_PASSIVE; // R6 R14
            else if (head_cfg.strobe_mode)
            begin
              strobe_n_reg <= 1'b0; // R5
              state_reg <= PT_STROBE;
            end
            else
              state_reg <= PT_WAIT; // R5
          end
        end
        PT_STROBE:
        begin
          if (rise)
          begin
            strobe_n_reg <= 1'b1; // R5
            state_reg <= PT_WAIT;
          end
        end
        PT_WAIT:
        begin
          if (done_job)
          begin
            attn_n_reg <= 1'b1;
            state_reg <= PT_IDLE;
          end
          else if (rise && wait_n_s)
            ws_cnt_reg <= ws_cnt_reg - 3'h1; // R12
        end
        PT_PASSIVE:
        begin
          if (done_job)
          begin
            attn_n_reg <= 1'b1;
            state_reg <= PT_IDLE;
          end
        end
        default:
          state_reg <= PT_IDLE;
      endcase
    end
  end

  // Job fields; passive reads collect data from local writes to the data register.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cur_write_reg <= 1'b0;
      cur_region_reg <= 2'h0;
      cur_addr_reg <= `ZERO_WORD;
      cur_data_reg <= `ZERO_WORD;
    end
    else if (i_ce)
    begin
      if (start_job)
      begin
        cur_write_reg <= (wf_count != '0);
        cur_region_reg <= (wf_count != '0) ? wf_head[65:64] : rd_region_reg;
        cur_addr_reg <= (wf_count != '0) ? wf_head[63:32] : rd_addr_reg;
        cur_data_reg <= (wf_count != '0) ? wf_head[31:0] : `ZERO_WORD;
      end
      else if (pt_data_wr && (state_reg == PT_PASSIVE) && !cur_write_reg)
        cur_data_reg <= pass_in; // R7
    end
  end

  // Host read answer and prefetch start, in either mode.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rvalid_reg <= 1'b0;
      pf_start_reg <= 1'b0;
      pf_sel_reg <= 2'h0;
      rdata_reg <= `ZERO_WORD;
    end
    else if (i_ce)
    begin
      rvalid_reg <= done_job && !cur_write_reg;
      pf_start_reg <= done_job && !cur_write_reg; // R11
      if (done_job && !cur_write_reg)
      begin
        pf_sel_reg <= cur_cfg.prefetch; // R10
        if (state_reg == PT_WAIT)
          rdata_reg <= cur_cfg.big_endian ? swap_bytes(data_s) : data_s; // R7
        else
          rdata_reg <= pass_in; // R22
      end
    end
  end

  assign o_transfer_attention_n = attn_n_reg;
  assign o_transfer_addr_strobe_n = strobe_n_reg;
  assign o_pt_rvalid = rvalid_reg;
  assign o_pt_rdata = rdata_reg;
  assign o_prefetch_start = pf_start_reg;
  assign o_prefetch_sel = pf_sel_reg;

  // ------
  // Local data bus drive.
  // ------
  logic [31:0] rd_mux; // Register read data.
  logic addr_next; // Strobe falls this edge, so the address must show with it.

  assign addr_next = start_job && active_s && head_cfg.strobe_mode;
  logic [31:0] pt_out; // Pass-through data in local byte order.
  logic [31:0] bus_reg; // Registered bus output.
  logic oe_reg; // Registered bus enable.

  assign pt_out = cur_cfg.big_endian ? swap_bytes(cur_data_reg) : cur_data_reg; // R7

  // Register read multiplexer; unmapped offsets and left-out layouts read as zero.
  always_comb
  begin
    case (byte_addr)
      `OFS_INCOMING_MBOX: rd_mux = in_mbox_reg; // R18
      `OFS_OUTGOING_MBOX: rd_mux = out_mbox_reg;
      `OFS_TRANSFER_ADDR: rd_mux = cur_addr_reg;
      `OFS_TRANSFER_DATA: rd_mux = pt_out;
      `OFS_REGION_CONFIG: rd_mux = cfg_value;
      default: rd_mux = `ZERO_WORD;
    endcase
  end

  // Register reads win the bus; otherwise a strobe-mode job drives address, then an active write drives data.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      bus_reg <= `ZERO_WORD;
      oe_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      oe_reg <= rd_level || addr_next || (state_reg == PT_STROBE) || ((state_reg == PT_WAIT) && cur_write_reg);
      if (rd_level)
        bus_reg <= rd_mux; // R15
      else if (addr_next)
        bus_reg <= (wf_count != '0) ? wf_head[63:32] : rd_addr_reg; // R5
      else if (state_reg == PT_STROBE)
        bus_reg <= cur_addr_reg; // R5
      else
        bus_reg <= pt_out;
    end
  end

  assign o_data = bus_reg;
  assign o_data_oe = oe_reg;

endmodule : pass_thru_local_regs

/* sim/pass_thru_local_regs_checker.sv */
// Port checks for the local register bank.
`timescale 1ns/10ps
module pass_thru_local_regs_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_host_cfg_we,
  input wire logic [3:0] i_host_cfg_be,
  input wire logic [31:0] i_host_cfg_wdata,
  input wire logic [31:0] o_host_cfg_rdata,
  input wire logic i_host_irq_en,
  input wire logic o_host_irq,
  input wire logic o_pt_rvalid,
  input wire logic o_transfer_attention_n,
  input wire logic o_transfer_addr_strobe_n,
  input wire logic o_data_oe
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // The strobe comes back after one add-on period of eight clocks.
  sequence strobe_end_s;
    ##[6:10] o_transfer_addr_strobe_n;
  endsequence
  cfg_reset_a: assert property ($rose(i_rst_n) |-> o_host_cfg_rdata == 32'h80808080)
    else $error("config reset value wrong");
  pins_idle_a: assert property ($rose(i_rst_n) |-> o_transfer_attention_n && o_transfer_addr_strobe_n && !o_data_oe)
    else $error("pins not idle after reset");
  host_lane_a: assert property (i_host_cfg_we && i_host_cfg_be[0] |=> o_host_cfg_rdata[7:0] == $past(i_host_cfg_wdata[7:0]))
    else $error("host lane write lost");
  irq_pulse_a: assert property (o_host_irq |=> !o_host_irq)
    else $error("irq longer than one cycle");
  irq_enable_a: assert property ($rose(o_host_irq) |-> $past(i_host_irq_en))
    else $error("irq while disabled");
  rvalid_pulse_a: assert property (o_pt_rvalid |=> !o_pt_rvalid)
    else $error("rvalid longer than one cycle");
  strobe_job_a: assert property (!o_transfer_addr_strobe_n |-> !o_transfer_attention_n)
    else $error("strobe outside a job");
  strobe_len_a: assert property ($fell(o_transfer_addr_strobe_n) |-> strobe_end_s)
    else $error("strobe length wrong");
  done_idle_a: assert property (o_pt_rvalid |-> o_transfer_attention_n)
    else $error("read done while job open");
endmodule : pass_thru_local_regs_checker

/* sim/addon_partner.sv */
// Add-on side partner: free add-on clock and wait stretching.
`timescale 1ns/10ps
module addon_partner (
  input wire logic i_attention_n,
  input wire logic [3:0] i_hold,
  output logic o_addon_clk,
  output logic o_wait_n
);
  logic [3:0] left; // Rises still to stretch in this job.
  // The clock runs free, offset from the system clock on purpose.
  initial
  begin
    o_addon_clk = 1'b0;
    o_wait_n = 1'b1;
    #7;
    forever #200 o_addon_clk = ~o_addon_clk;
  end
  // Wait is held low for the asked number of rises of each job.
  always @(posedge o_addon_clk)
  begin
    left <= i_attention_n ? i_hold : ((left == 4'h0) ? left : left - 4'h1);
    o_wait_n <= i_attention_n || left == 4'h0;
  end
endmodule : addon_partner

/* sim/pass_thru_local_regs_tb_top.sv */
// Self-checking bench of the local register bank.
`timescale 1ns/10ps
`include "pass_thru_regs.svh"
module pass_thru_local_regs_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, sel_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, act = 1'b1, hwe = 1'b0, mwe = 1'b0;
  logic ien = 1'b1, pv = 1'b0, pw = 1'b0, aclk, wait_n, atn_n, stb_n, oe, irq, rdy, rv, pfs;
  logic [3:0] be = 4'h0, hbe = 4'h0, hold = 4'h0;
  logic [1:0] preg = 2'h0, pfsel;
  logic [6:2] addr = 5'h00;
  logic [31:0] din = 32'h0, hdat = 32'h0, paddr = 32'h0, dout, hcfg, hmbox, prd, r, m, e;
  logic [31:0] irqs = 32'h0, lo = 32'h0, sl = 32'h0, bad = 32'h0, rvs = 32'h0, pfn = 32'h0;
  int seed = 85, err_total = 0, check_count = 0, n;
  always #25 clk = ~clk;
  pass_thru_local_regs i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_addon_clk(aclk), .i_select_n(sel_n),
    .i_byte_enables(be), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(addr), .i_data(din), .o_data(dout), .o_data_oe(oe),
    .i_active_mode(act), .i_transfer_wait_n(wait_n), .o_transfer_attention_n(atn_n), .o_transfer_addr_strobe_n(stb_n),
    .i_host_cfg_we(hwe), .i_host_cfg_be(hbe), .i_host_cfg_wdata(hdat), .o_host_cfg_rdata(hcfg), .i_host_mbox_we(mwe),
    .i_host_mbox_be(hbe), .i_host_mbox_wdata(hdat), .o_host_mbox_rdata(hmbox), .i_host_irq_en(ien), .o_host_irq(irq),
    .i_pt_valid(pv), .o_pt_ready(rdy), .i_pt_write(pw), .i_pt_region(preg), .i_pt_addr(paddr), .i_pt_wdata(~paddr),
    .o_pt_rdata(prd), .o_pt_rvalid(rv), .o_prefetch_start(pfs), .o_prefetch_sel(pfsel));
  addon_partner i_partner (.i_attention_n(atn_n), .i_hold(hold), .o_addon_clk(aclk), .o_wait_n(wait_n));
  // Event counters, so that short pulses are never missed between checks.
  always @(posedge clk)
  begin
    if (irq === 1'b1) irqs <= irqs + 32'h1;
    if (atn_n === 1'b0) lo <= lo + 32'h1;
    if (stb_n === 1'b0) sl <= sl + 32'h1;
    if (stb_n === 1'b0 && dout !== paddr) bad <= bad + 32'h1;
    if (rv === 1'b1) rvs <= rvs + 32'h1;
    if (pfs === 1'b1) pfn <= pfn + 32'h1;
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(input int k);
    if (k >= 300)
    begin
      err_total++;
      $display("Error at %0t: wait timed out", $time);
      end_sim();
    end
  endtask : tmo
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : cyc
  // One local access spanning one add-on rise; read data is caught while held.
  task automatic acc(input logic w, input logic [6:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge aclk);
    cyc(1);
    {sel_n, be, addr, din, wr_n, rd_n} = {1'b0, b, a[6:2], d, ~w, w};
    @(posedge aclk);
    cyc(6);
    r = dout;
    {sel_n, wr_n, rd_n} = 3'h7;
  endtask : acc
  task automatic hcw(input logic [3:0] b, input logic [31:0] d, input logic mb);
    {hbe, hdat, hwe, mwe} = {b, d, ~mb, mb};
    cyc(1);
    {hwe, mwe} = 2'h0;
  endtask : hcw
  task automatic job(input logic w, input logic [1:0] g);
    {pw, preg, pv, n} = {w, g, 1'b1, 32'h0};
    for (n = 0; rdy !== 1'b1 && n < 300; n++) cyc(1);
    cyc(1);
    pv = 1'b0;
    tmo(n);
  endtask : job
  task automatic wait_atn(input logic v);
    for (n = 0; atn_n !== v && n < 300; n++) cyc(1);
    tmo(n);
  endtask : wait_atn
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] b);
    for (int i = 0; i < 4; i++) if (b[i]) o[8*i+:8] = d[8*i+:8];
    return o;
  endfunction : merge
  initial
  begin
    cyc(4);
    rst_n = 1'b1;
    cyc(20);
    chk(hcfg, `REGION_CONFIG_RESET);
    acc(1'b0, `OFS_REGION_CONFIG, 4'hF, 32'h0);
    chk(r, `REGION_CONFIG_RESET);
    m = $random(seed);
    hcw(4'hF, m, 1'b1);
    acc(1'b0, `OFS_INCOMING_MBOX, 4'hF, 32'h0);
    chk(r, m);
    acc(1'b1, `OFS_INCOMING_MBOX, 4'hF, ~m);
    acc(1'b0, `OFS_INCOMING_MBOX, 4'h1, 32'h0);
    chk(r, m);
    chk(irqs, 32'h2);
    ien = 1'b0;
    acc(1'b0, `OFS_INCOMING_MBOX, 4'hF, 32'h0);
    chk(irqs, 32'h2);
    acc(1'b1, `OFS_OUTGOING_MBOX, 4'hF, ~m);
    chk(hmbox, ~m);
    acc(1'b0, `OFS_MBOX_STATUS, 4'hF, 32'h0);
    chk(r, `ZERO_WORD);
    $display("test mailbox done");
    e = `REGION_CONFIG_RESET;
    for (int i = 0; i < 16; i++)
    begin
      m = $random(seed);
      acc(1'b1, `OFS_REGION_CONFIG, i[3:0], m);
      e = merge(e, m, i[3:0]);
      chk(hcfg, e);
    end
    m = $random(seed);
    hcw(4'hF, m, 1'b0);
    acc(1'b0, `OFS_REGION_CONFIG, 4'hF, 32'h0);
    chk(r, m);
    $display("test config done");
    for (int j = 0; j < 2; j++)
    begin
      hcw(4'h1, j ? 32'h07 : 32'h83, 1'b0);
      hold = j ? 4'h0 : 4'h2;
      paddr = $random(seed);
      {lo, sl, bad} = 96'h0;
      job(1'b1, 2'h0);
      wait_atn(1'b0);
      wait_atn(1'b1);
      chk(sl, j ? 32'h0 : 32'h8);
      chk(bad, 32'h0);
      chk({31'h0, lo >= (j ? 56 : 24) && lo <= (j ? 80 : 64)}, 32'h1);
    end
    $display("test active done");
    act = 1'b0;
    hcw(4'h2, 32'hDF00, 1'b0);
    {sl, rvs, pfn} = 96'h0;
    m = $random(seed);
    job(1'b0, 2'h1);
    acc(1'b1, `OFS_TRANSFER_DATA, 4'hF, m);
    cyc(10);
    chk(rvs, 32'h1);
    chk(prd, {m[7:0], m[15:8], m[23:16], m[31:24]});
    chk(sl, 32'h0);
    chk(pfn, 32'h1);
    chk({30'h0, pfsel}, 32'h3);
    $display("test passive done");
    end_sim();
  end
endmodule : pass_thru_local_regs_tb_top
bind pass_thru_local_regs pass_thru_local_regs_checker i_chk (.*);
